// [logic/adc_sequencer_control.sv]
// Purpose: control register, sequencer and result register of the 8-channel converter
// Assumes: AXI4-Lite slave, one write and one read at a time, 100 MHz clock
// Notes: analog array is outside; comparator result arrives per convert cycle
`include "adc_seq_map.svh"
module adc_sequencer_control (
    input wire logic clock,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // low power request from the device core
    input wire logic low_power,
    // successive approximation comparator from the analog array
    input wire logic comparator,
    // analog array control
    output logic adc_power,
    output logic sample,
    output logic adc_select,
    output logic sample_switch,
    output logic load,
    output logic [2:0] pos_channel,
    output logic [2:0] neg_channel,
    output logic neg_is_channel,
    output logic [7:0] sar_trial,
    output logic conv_clock,
    output logic busy
);
    logic [7:0] adc_control_reg; // channel, mode, prescaler
    logic [7:0] adc_result_reg; // last completed result
    logic [7:0] sar; // approximation in progress
    logic [3:0] phase_count; // cycles left in a phase
    logic sub_half; // second half of sample period
    logic was_running; // sequence active when low power came
    logic lp_sync1, lp_sync2, lp_sync3; // low power synchroniser
    logic lp; // filtered low power level
    adc_seq_pkg::seq_state_t state, next_state;

    // write channel holding registers
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // write channel: take address and data in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire logic aw_now = s_axi_awvalid && s_axi_awready;
    wire logic w_now = s_axi_wvalid && s_axi_wready;
    wire logic aw_have = aw_held || aw_now;
    wire logic w_have = w_held || w_now;
    wire logic [7:0] aw_eff = aw_held ? aw_addr : s_axi_awaddr;
    wire logic [31:0] w_eff = w_held ? w_data : s_axi_wdata;
    wire logic [3:0] strb_eff = w_held ? w_strb : s_axi_wstrb;
    wire logic wr_fire = aw_have && w_have && !s_axi_bvalid;
    wire logic wr_ctrl = wr_fire && (aw_eff[7:2] == `ADC_CONTROL_OFFSET >> 2);
    wire logic wr_res = wr_fire && (aw_eff[7:2] == `ADC_RESULT_OFFSET >> 2); // see RL17
    wire logic wr_bad = !(wr_ctrl || wr_res);
    // a control write counts only if its low byte lane is enabled
    wire logic ctrl_load = wr_ctrl && strb_eff[0];
    wire logic [7:0] new_ctrl = w_eff[7:0];

    // hold address and data until both are present
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            aw_held <= aw_have && !wr_fire;
            w_held <= w_have && !wr_fire;
            if (aw_now) aw_addr <= s_axi_awaddr;
            if (w_now) w_data <= s_axi_wdata;
            if (w_now) w_strb <= s_axi_wstrb;
        end
    end

    // write response, slverr for an unmapped address
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? `ADC_RESP_SLVERR : `ADC_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: one read at a time
    assign s_axi_arready = !s_axi_rvalid;
    wire logic rd_fire = s_axi_arvalid && s_axi_arready;
    wire logic rd_ctrl = s_axi_araddr[7:2] == `ADC_CONTROL_OFFSET >> 2;
    wire logic rd_res = s_axi_araddr[7:2] == `ADC_RESULT_OFFSET >> 2;

    // read data register; result register is stable since load updates it atomically
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ADC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ctrl ? {24'h000000, adc_control_reg} :
                           rd_res ? {24'h000000, adc_result_reg} : 32'h00000000; // see RL22
            s_axi_rresp <= (rd_ctrl || rd_res) ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control register, cleared at reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            adc_control_reg <= `ADC_CONTROL_RESET; // see RL21
        end else if (ctrl_load) begin
            adc_control_reg <= new_ctrl;
        end
    end

    // field decode
    wire logic [2:0] chan = adc_control_reg[`ADC_CHAN_MSB:`ADC_CHAN_LSB]; // see RL1
    wire logic mode_diff = adc_control_reg[`ADC_MODE_DIFF_BIT]; // see RL5
    wire logic mode_cont = adc_control_reg[`ADC_MODE_CONT_BIT]; // see RL5
    wire logic [2:0] presc = adc_control_reg[`ADC_PRESC_MSB:`ADC_PRESC_LSB];
    wire logic [2:0] presc_next = ctrl_load ? new_ctrl[`ADC_PRESC_MSB:`ADC_PRESC_LSB] : presc;

    // low power pin passes three flops, changes once the last two agree
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lp_sync1 <= 1'b0;
            lp_sync2 <= 1'b0;
            lp_sync3 <= 1'b0;
            lp <= 1'b0;
        end else begin
            lp_sync1 <= low_power;
            lp_sync2 <= lp_sync1;
            lp_sync3 <= lp_sync2;
            if (lp_sync2 == lp_sync3) lp <= lp_sync3;
        end
    end

    // low power edges
    logic lp_d;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) lp_d <= 1'b0;
        else lp_d <= lp;
    end
    wire logic lp_exit = lp_d && !lp;
    wire logic running = (state != adc_seq_pkg::st_off);
    // restart after low power only if a sequence was interrupted
    wire logic resume = lp_exit && was_running && (presc != 3'h0); // see RL18
    wire logic start = (ctrl_load && (new_ctrl[2:0] != 3'h0)) || resume; // see RL2

    // remember whether a sequence was cut short by low power
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            was_running <= 1'b0;
        end else if (ctrl_load) begin
            was_running <= 1'b0;
        end else if (lp && !lp_d) begin
            was_running <= running; // see RL18
        end
    end

    logic tick;
    // converter clock divider, realigned on each start
    adc_prescaler u_prescaler (
        .clock(clock),
        .reset_n(reset_n),
        .presc_sel(presc_next),
        .restart(start),
        .tick(tick),
        .conv_clock(conv_clock)
    );

    // next state on each converter falling edge
    always_comb begin
        next_state = state;
        unique case (state)
            adc_seq_pkg::st_off: next_state = state;
            adc_seq_pkg::st_wait_edge: next_state = adc_seq_pkg::st_reset; // see RL9
            adc_seq_pkg::st_reset: next_state = adc_seq_pkg::st_sample; // see RL16
            adc_seq_pkg::st_sample:
                next_state = (phase_count == 4'h1) ? adc_seq_pkg::st_convert : state;
            adc_seq_pkg::st_convert:
                next_state = (phase_count == 4'h1) ? adc_seq_pkg::st_load : state;
            adc_seq_pkg::st_load: // see RL11
                next_state = mode_cont ? adc_seq_pkg::st_gap : adc_seq_pkg::st_off;
            adc_seq_pkg::st_gap: next_state = adc_seq_pkg::st_sample; // see RL12
        endcase
    end

    // sequencer: low power or inhibit stops, and wins over start
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= adc_seq_pkg::st_off;
        end else if (lp || (ctrl_load && new_ctrl[2:0] == 3'h0)) begin
            state <= adc_seq_pkg::st_off; // see RL7
        end else if (start) begin
            state <= adc_seq_pkg::st_wait_edge; // see RL23
        end else if (tick) begin
            state <= next_state;
        end
    end

    // phase counter and sample half marker
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_count <= 4'h0;
        end else if (tick && next_state != state) begin
            phase_count <= (next_state == adc_seq_pkg::st_convert) ? `ADC_CONVERT_CYCLES :
                           `ADC_SAMPLE_CYCLES;
        end else if (tick && phase_count != 4'h0) begin
            phase_count <= phase_count - 4'h1;
        end
    end

    // midpoint of sample: after the first whole converter period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sub_half <= 1'b0;
        end else if (state != adc_seq_pkg::st_sample) begin
            sub_half <= 1'b0;
        end else if (tick) begin
            sub_half <= 1'b1; // see RL10
        end
    end

    // successive approximation and result load
    wire logic [3:0] bit_idx = phase_count - 4'h1;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sar <= 8'h00;
            adc_result_reg <= 8'h00;
        end else if (tick && state == adc_seq_pkg::st_sample && next_state != state) begin
            sar <= 8'h80;
        end else if (tick && state == adc_seq_pkg::st_convert) begin
            sar[bit_idx[2:0]] <= comparator; // array runs on this clock, settles in a period
            if (bit_idx != 4'h0) sar[bit_idx[2:0] - 3'h1] <= 1'b1;
        end else if (tick && state == adc_seq_pkg::st_load) begin
            adc_result_reg <= sar; // see RL13
        end
    end

    // trial word straight from its flop, so a divide-by-1 period still sees it
    assign sar_trial = sar;

    // analog array controls, registered
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            adc_power <= 1'b0;
            sample <= 1'b0;
            adc_select <= 1'b0;
            sample_switch <= 1'b0;
            load <= 1'b0;
            pos_channel <= 3'h0;
            neg_channel <= 3'h0;
            neg_is_channel <= 1'b0;
            busy <= 1'b0;
        end else begin
            adc_power <= running || start; // see RL8
            sample <= state == adc_seq_pkg::st_sample; // see RL9
            sample_switch <= state == adc_seq_pkg::st_sample; // see RL19
            adc_select <= (state == adc_seq_pkg::st_sample && sub_half) ||
                          state == adc_seq_pkg::st_convert || state == adc_seq_pkg::st_load;
            load <= state == adc_seq_pkg::st_load;
            pos_channel <= chan; // see RL3
            neg_channel <= chan ^ 3'h1; // see RL4
            neg_is_channel <= mode_diff;
            busy <= running;
        end
    end
endmodule

// [logic/adc_seq_map.svh]
// Purpose: offsets, field positions, reset values and counts for the converter sequencer
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes: included by its bare name
// Functional notes
// RL1: channel 7:5, mode 4:3, prescaler 2:0
// RL2: any control write starts a new sequence; code starts one only for a nonzero prescaler
// RL3: single-ended routes channel n as positive
// RL4: differential pairs even/odd, sign by code
// RL5: mode codes: single/continuous, single-ended/differential
// RL6: prescaler codes map to fixed divide ratios
// RL7: prescaler zero stops clock, powers down
// RL8: power up as the write begins
// RL9: sample two periods from first falling edge
// RL10: select asserts mid sample period
// RL11: single mode completion powers converter down
// RL12: continuous restarts after one deselected period
// RL13: result loaded, reads masked during load; code does not mask reads
// RL14: converter clock is oscillator over ratio
// RL15: software keeps converter clock in range
// RL16: twelve cycles: reset, sample, convert, load
// RL17: result register ignores writes
// RL18: low power stops; running sequence restarts after
// RL19: sampling switch closed only during sample
// RL20: software slows clock for high source resistance
// RL21: reset clears control and powers down
// RL22: continuous result readable any time
// RL23: new write abandons conversion in progress
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define ADC_CONTROL_OFFSET 8'h00
`define ADC_RESULT_OFFSET 8'h04
`define ADC_CHAN_MSB 7
`define ADC_CHAN_LSB 5
`define ADC_MODE_DIFF_BIT 4
`define ADC_MODE_CONT_BIT 3
`define ADC_PRESC_MSB 2
`define ADC_PRESC_LSB 0
`define ADC_CONTROL_RESET 8'h00
`define ADC_SAMPLE_CYCLES 4'h2
`define ADC_CONVERT_CYCLES 4'h8
`define ADC_RESP_OKAY 2'b00
`define ADC_RESP_SLVERR 2'b10
`endif

// [logic/adc_seq_pkg.sv]
// Purpose: types shared by the converter sequencer
// Assumes: nothing
// Notes: constants live in adc_seq_map.svh
package adc_seq_pkg;
    // sequence phases, one converter clock each except off, sample and convert
    typedef enum logic [2:0] {
        st_off,
        st_wait_edge,
        st_reset,
        st_sample,
        st_convert,
        st_load,
        st_gap
    } seq_state_t;
endpackage

// [logic/adc_prescaler.sv]
// Purpose: divide the oscillator clock into converter clock falling-edge ticks
// Assumes: ratio 0 means inhibit
// Notes: emits one tick per converter period and, for ratios above 1, a square wave for observation
module adc_prescaler (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [2:0] presc_sel,
    input wire logic restart,
    output logic tick,
    output logic conv_clock
);
    // ratio table for the prescaler code
    function automatic logic [4:0] ratio_of(input logic [2:0] sel);
        unique case (sel)
            3'h0: ratio_of = 5'h00;
            3'h1: ratio_of = 5'h01;
            3'h2: ratio_of = 5'h02;
            3'h3: ratio_of = 5'h04;
            3'h4: ratio_of = 5'h06;
            3'h5: ratio_of = 5'h0c;
            3'h6: ratio_of = 5'h08;
            3'h7: ratio_of = 5'h10;
        endcase
    endfunction

    logic [4:0] count; // cycles into current converter period
    wire logic [4:0] ratio = ratio_of(presc_sel); // see RL6
    wire logic inhibit = (ratio == 5'h00); // see RL7
    wire logic period_end = !inhibit && (count == ratio - 5'h01);
    wire logic [4:0] half = ratio >> 1;

    // period counter, restarted on a control write
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= 5'h00;
        end else if (restart || inhibit || period_end) begin
            count <= 5'h00;
        end else begin
            count <= count + 5'h01; // see RL14
        end
    end

    // falling-edge tick and the clock wave itself
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick <= 1'b0;
            conv_clock <= 1'b0;
        end else begin
            tick <= period_end && !restart;
            conv_clock <= !inhibit && (count < half || ratio == 5'h01);
        end
    end
endmodule

// [verification/adc_seq_monitor.sv]
// Purpose: port checks of the converter sequencer
// Assumes: control word at byte 0x00, one clock domain
// Notes: bound to the top module below
module adc_seq_monitor (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic low_power,
    input wire logic adc_power,
    input wire logic sample,
    input wire logic sample_switch,
    input wire logic adc_select,
    input wire logic load,
    input wire logic [2:0] pos_channel,
    input wire logic [2:0] neg_channel,
    input wire logic neg_is_channel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // control write taken with byte 0 enabled
    wire logic ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 8'h00 && s_axi_wstrb[0] && !low_power;
    a_switch_tracks: assert property (sample_switch == sample)
        else $error("sampling switch differs from sample");
    a_select_mid: assert property ($rose(adc_select) |-> sample && $past(sample))
        else $error("select rose outside mid sample");
    a_load_selected: assert property (load |-> adc_select && !sample)
        else $error("load without select or during sample");
    a_pair_swap: assert property (neg_is_channel && adc_power |->
        neg_channel == (pos_channel ^ 3'h1)) else $error("pair partner wrong");
    a_write_wakes: assert property (ctl_wr && s_axi_wdata[2:0] != 3'h0 |=>
        ##[0:1] adc_power) else $error("write did not power up");
    a_zero_sleeps: assert property (ctl_wr && s_axi_wdata[2:0] == 3'h0 |=>
        ##[0:1] !adc_power) else $error("zero prescaler left power on");
    a_low_power_off: assert property (low_power [*6] |=> !adc_power && !sample)
        else $error("converter on in low power");
    a_sample_powered: assert property (sample |-> adc_power)
        else $error("sample while powered down");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
endmodule
bind adc_sequencer_control adc_seq_monitor adc_seq_monitor_inst (.clock(clock),
    .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .low_power(low_power),
    .adc_power(adc_power), .sample(sample), .sample_switch(sample_switch),
    .adc_select(adc_select), .load(load), .pos_channel(pos_channel),
    .neg_channel(neg_channel), .neg_is_channel(neg_is_channel));

// [verification/adc_analog_model.sv]
// Purpose: sample-and-hold and comparator of the analog array
// Assumes: channel n level in levels[8n+7:8n]
// Notes: a negative difference reads as zero
module adc_analog_model (
    input wire logic clock,
    input wire logic [63:0] levels,
    input wire logic [2:0] pos_channel,
    input wire logic [2:0] neg_channel,
    input wire logic neg_is_channel,
    input wire logic sample_switch,
    input wire logic [7:0] sar_trial,
    output logic comparator
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] held = 8'h00; // charge on the array
    logic [8:0] diff; // positive minus negative input
    // negative input is ground unless a pair is selected
    assign diff = {1'b0, levels[pos_channel * 8 +: 8]}
        - (neg_is_channel ? {1'b0, levels[neg_channel * 8 +: 8]} : 9'h000);
    // array charges only while the switch is closed
    always @(posedge clock) begin
        if (sample_switch) begin
            held <= diff[8] ? 8'h00 : diff[7:0];
        end
    end
    // held input at or above the trial word
    assign comparator = held >= sar_trial;
endmodule

// [verification/adc_sequencer_control_tb.sv]
// Purpose: self-checking bench of the converter sequencer
// Assumes: control 0x00, result 0x04
// Notes: prescaler codes 1 to 7 all exercised
module adc_sequencer_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, reset_n = 1'b0, low_power = 1'b0, comparator;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sar_trial;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic adc_power, sample, adc_select, sample_switch, load, neg_is_channel, conv_clock, busy;
    logic [2:0] pos_channel, neg_channel;
    logic [63:0] lv = 64'h0; // channel levels
    logic [31:0] seed = 32'h00000053;
    int err_count = 0, samples_checked = 0;
    int ratio_tab[8] = '{0, 1, 2, 4, 6, 12, 8, 16};
    always #5 clock = ~clock;
    adc_sequencer_control adc_sequencer_control_inst (.clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .low_power(low_power),
        .comparator(comparator), .adc_power(adc_power), .sample(sample),
        .adc_select(adc_select), .sample_switch(sample_switch), .load(load),
        .pos_channel(pos_channel), .neg_channel(neg_channel),
        .neg_is_channel(neg_is_channel), .sar_trial(sar_trial), .conv_clock(conv_clock),
        .busy(busy));
    adc_analog_model adc_analog_model_inst (.clock(clock), .levels(lv),
        .pos_channel(pos_channel), .neg_channel(neg_channel),
        .neg_is_channel(neg_is_channel), .sample_switch(sample_switch),
        .sar_trial(sar_trial), .comparator(comparator));
    // xorshift source of channels and levels
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected result: positive minus negative, floored at zero
    function automatic logic [31:0] exp_val(input logic [2:0] ch, input logic dif);
        int p, n;
        p = lv[ch * 8 +: 8];
        n = dif ? lv[(ch ^ 3'h1) * 8 +: 8] : 0;
        return p > n ? p - n : 0;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ha, hw, hb;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(negedge clock);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge clock);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 200) err_count++;
    endtask
    // axi4-lite read, ready raised late once the data stands
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ha, hr;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(negedge clock);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid === 1'b1 && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock);
            if (ha) s_axi_arvalid <= 1'b0;
            if (n == 1) s_axi_rready <= 1'b1;
            if (hr) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 200) err_count++;
    endtask
    // cycles that sample, load or busy stays at a level
    task automatic hold_len(input int s, input logic lvl, output int n);
        n = 0;
        while ((s == 0 ? sample : (s == 1 ? load : busy)) === lvl && n < 3000) begin
            @(negedge clock);
            n++;
        end
    endtask
    initial begin
        #1000000;
        err_count++;
        close_out();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] c;
        int n;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        rd(8'h00, d, r);
        chk(d, 32'h0);
        chk(adc_power, 1'b0);
        rd(8'h08, d, r);
        chk(r, 2'b10);
        wr(8'h04, 32'h5a, r);
        chk(r, 2'b00);
        rd(8'h04, d, r);
        chk(d, 32'h0);
        // prescaler codes 1 to 7, single conversions, both input modes
        // bench clock stands for the oscillator; ideal low-resistance sources
        for (int k = 1; k < 8; k++) begin
            lv <= {xs(), xs()};
            c = (xs() & 8'he0) | (k[0] ? 8'h10 : 8'h00) | k;
            wr(8'h00, {24'h0, c}, r);
            hold_len(0, 1'b0, n);
            hold_len(0, 1'b1, n);
            chk(n, 2 * ratio_tab[k]);
            hold_len(1, 1'b0, n);
            chk(n, 8 * ratio_tab[k]);
            hold_len(1, 1'b1, n);
            chk(n, ratio_tab[k]);
            chk({neg_is_channel, pos_channel}, {c[4], c[7:5]});
            chk(neg_channel, {c[7:6], ~c[5]});
            hold_len(2, 1'b1, n);
            chk(adc_power, 1'b0);
            rd(8'h04, d, r);
            chk(d, exp_val(c[7:5], c[4]));
            rd(8'h00, d, r);
            chk(d, {24'h0, c});
        end
        // differential continuous scan of pair 2,3, then a rewrite mid-conversion
        wr(8'h00, 32'h5b, r);
        hold_len(1, 1'b0, n);
        hold_len(1, 1'b1, n);
        hold_len(0, 1'b0, n);
        chk(n, 4);
        rd(8'h04, d, r);
        chk(d, exp_val(3'h2, 1'b1));
        wr(8'h00, 32'ha3, r);
        hold_len(2, 1'b1, n);
        rd(8'h04, d, r);
        chk(d, exp_val(3'h5, 1'b0));
        // low power during a scan, then resume
        wr(8'h00, 32'h4b, r);
        hold_len(0, 1'b0, n);
        @(posedge clock);
        low_power <= 1'b1;
        repeat (20) @(posedge clock);
        chk(adc_power, 1'b0);
        low_power <= 1'b0;
        hold_len(0, 1'b0, n);
        chk(sample, 1'b1);
        // zero prescaler stops the clock and powers down
        wr(8'h00, 32'h48, r);
        repeat (4) @(posedge clock);
        chk({adc_power, conv_clock, busy}, 3'h0);
        close_out();
    end
endmodule
